/* design/hid_cpu_regs.sv */
`timescale 1ns/1ps
module hid_cpu_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // set and clear masks
  input  wire logic [63:0] ldt_set,
  input  wire logic [63:0] ldt_clr,
  input  wire logic [63:0] mbox_set,
  input  wire logic [63:0] mbox_clr,
  // register contents
  output logic      [63:0] link_irq,
  output logic      [63:0] mbox,
  output logic             link_pend,
  output logic             mbox_pend
);
  logic [63:0] link_irq_reg;
  logic [63:0] link_irq_next;
  logic [63:0] mbox_reg;
  logic [63:0] mbox_next;

  // set applied after clear so a new event never vanishes
  always_comb begin
    link_irq_next = (link_irq_reg & ~ldt_clr) | ldt_set;
    mbox_next     = (mbox_reg & ~mbox_clr) | mbox_set;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_irq_reg <= hid_pkg::LINK_IRQ_RST;
      mbox_reg     <= hid_pkg::MBOX_RST;
    end else begin
      link_irq_reg <= link_irq_next;
      mbox_reg     <= mbox_next;
    end
  end

  assign link_irq  = link_irq_reg;
  assign mbox      = mbox_reg;
  assign link_pend = |link_irq_reg;
  assign mbox_pend = |mbox_reg;
endmodule : hid_cpu_regs

/* design/hid_msg_decoder.sv */
`timescale 1ns/1ps
module hid_msg_decoder #(
  parameter int NUM_CPU = 2
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // message register write, link or CPU
  input  wire logic                       msg_wr_en,
  input  wire logic [63:0]                msg_wr_data,
  // link-interrupt clear location, per CPU
  input  wire logic [NUM_CPU-1:0]         ldt_clr_en,
  input  wire logic [63:0]                ldt_clr_data,
  // mailbox clear location, per CPU
  input  wire logic [NUM_CPU-1:0]         mbox_clr_en,
  input  wire logic [63:0]                mbox_clr_data,
  // acknowledge-range byte read
  input  wire logic                       iack_rd_en,
  input  wire logic                       southbridge_on_link_cfg,
  // per-CPU registers
  output logic      [NUM_CPU-1:0][63:0]   link_irq,
  output logic      [NUM_CPU-1:0][63:0]   mbox,
  output logic      [NUM_CPU-1:0]         link_irq_pend,
  output logic      [NUM_CPU-1:0]         mbox_pend,
  // last decoded message
  output logic      [7:0]                 last_vec,
  output logic      [NUM_CPU-1:0]         last_tgt,
  output logic                            last_level,
  output logic                            msg_done,
  output logic                            msg_drop,
  // acknowledge routing
  output logic                            iack_link_req,
  output logic                            iack_pci_req
);
  logic [2:0]              m_type;
  logic                    m_level;
  logic                    m_logical;
  logic [7:0]              m_dest;
  logic [7:0]              m_vec;
  logic [7:0]              eff_vec;
  logic                    nonvec;
  logic                    rsvd;
  logic [NUM_CPU-1:0]      sel;
  logic [NUM_CPU-1:0]      tgt;
  logic                    to_link;
  logic                    to_mbox;
  logic                    drop;
  logic [63:0]             bit_mask;
  logic [NUM_CPU-1:0][63:0] ldt_set;
  logic [NUM_CPU-1:0][63:0] ldt_clr;
  logic [NUM_CPU-1:0][63:0] mbox_set;
  logic [NUM_CPU-1:0][63:0] mbox_clr;

  logic [7:0]              last_vec_reg;
  logic [7:0]              last_vec_next;
  logic [NUM_CPU-1:0]      last_tgt_reg;
  logic [NUM_CPU-1:0]      last_tgt_next;
  logic                    last_level_reg;
  logic                    last_level_next;
  logic                    done_reg;
  logic                    done_next;
  logic                    drop_reg;
  logic                    drop_next;
  logic                    iack_link_reg;
  logic                    iack_link_next;
  logic                    iack_pci_reg;
  logic                    iack_pci_next;

  // field extraction; bits above 20 are ignored
  always_comb begin
    m_type    = msg_wr_data[hid_pkg::TYPE_LSB +: hid_pkg::TYPE_W];
    m_level   = msg_wr_data[hid_pkg::TRIG_BIT];
    m_logical = msg_wr_data[hid_pkg::DMODE_BIT];
    m_dest    = msg_wr_data[hid_pkg::DEST_LSB +: hid_pkg::DEST_W];
    m_vec     = msg_wr_data[hid_pkg::VEC_LSB +: hid_pkg::VEC_W];
  end

  // type classes and fixed vectors for the non-vectored kinds
  always_comb begin
    rsvd    = (m_type == hid_pkg::HID_MT_RSVD);
    nonvec  = (m_type >= hid_pkg::HID_MT_SMI) && !rsvd;
    eff_vec = m_vec;
    if (nonvec) begin
      eff_vec = 8'(hid_pkg::NV_VEC_BASE + {5'h00, m_type} - 8'h02);
    end
  end

  // destination decode; only CPUs that exist can be selected
  always_comb begin
    for (int i = 0; i < NUM_CPU; i++) begin
      if (m_logical) begin
        sel[i] = m_dest[i];
      end else begin
        sel[i] = (m_dest == 8'(i));
      end
    end
  end

  // arbitrated delivery picks the lowest numbered selected CPU;
  // no CPU reports what it is servicing, so lowest is the only fair choice
  always_comb begin
    tgt = sel;
    if (m_type == hid_pkg::HID_MT_ARB) begin
      tgt = '0;
      for (int i = NUM_CPU - 1; i >= 0; i--) begin
        if (sel[i]) begin
          tgt = NUM_CPU'(1) << i;
        end
      end
    end
  end

  // delivery class from the top two vector bits
  always_comb begin
    to_link  = msg_wr_en && !rsvd && (eff_vec[7:6] == hid_pkg::DELIV_LINK);
    to_mbox  = msg_wr_en && !rsvd && (eff_vec[7:6] == hid_pkg::DELIV_MBOX);
    drop     = msg_wr_en && (rsvd || eff_vec[7] || (tgt == '0));
    bit_mask = 64'h1 << eff_vec[hid_pkg::IDX_W-1:0];
  end

  // per-CPU masks; each write is applied in the cycle it arrives, so
  // messages take effect in exactly the order the bus delivers them
  always_comb begin
    for (int i = 0; i < NUM_CPU; i++) begin
      ldt_set[i]  = (to_link && tgt[i]) ? bit_mask : 64'h0;
      mbox_set[i] = (to_mbox && tgt[i]) ? bit_mask : 64'h0;
      ldt_clr[i]  = ldt_clr_en[i] ? ldt_clr_data : 64'h0;
      mbox_clr[i] = mbox_clr_en[i] ? mbox_clr_data : 64'h0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CPU; g++) begin : g_cpu
      hid_cpu_regs u_regs (
        .clk       (clk),
        .arst_n    (arst_n),
        .ldt_set   (ldt_set[g]),
        .ldt_clr   (ldt_clr[g]),
        .mbox_set  (mbox_set[g]),
        .mbox_clr  (mbox_clr[g]),
        .link_irq  (link_irq[g]),
        .mbox      (mbox[g]),
        .link_pend (link_irq_pend[g]),
        .mbox_pend (mbox_pend[g])
      );
    end
  endgenerate

  // last-message status and acknowledge routing
  always_comb begin
    last_vec_next   = last_vec_reg;
    last_tgt_next   = last_tgt_reg;
    last_level_next = last_level_reg;
    done_next       = msg_wr_en;
    drop_next       = drop;
    if (msg_wr_en) begin
      last_vec_next   = eff_vec;
      last_tgt_next   = rsvd ? '0 : tgt;
      last_level_next = m_level;
    end
    // the southbridge answers with the vector byte either way
    iack_link_next = iack_rd_en && southbridge_on_link_cfg;
    iack_pci_next  = iack_rd_en && !southbridge_on_link_cfg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_vec_reg   <= hid_pkg::VEC_RST;
      last_tgt_reg   <= '0;
      last_level_reg <= 1'b0;
      done_reg       <= 1'b0;
      drop_reg       <= 1'b0;
      iack_link_reg  <= 1'b0;
      iack_pci_reg   <= 1'b0;
    end else begin
      last_vec_reg   <= last_vec_next;
      last_tgt_reg   <= last_tgt_next;
      last_level_reg <= last_level_next;
      done_reg       <= done_next;
      drop_reg       <= drop_next;
      iack_link_reg  <= iack_link_next;
      iack_pci_reg   <= iack_pci_next;
    end
  end

  assign last_vec      = last_vec_reg;
  assign last_tgt      = last_tgt_reg;
  assign last_level    = last_level_reg;
  assign msg_done      = done_reg;
  assign msg_drop      = drop_reg;
  assign iack_link_req = iack_link_reg;
  assign iack_pci_req  = iack_pci_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic       wr_fixed_vec00;
  logic [2:0] wt;
  logic [7:0] wd;
  logic [7:0] wv;
  logic       wr_phys0;
  logic       clr_idle;
  assign wt = msg_wr_data[2:0];
  assign wd = msg_wr_data[12:5];
  assign wv = msg_wr_data[20:13];
  assign wr_fixed_vec00 = msg_wr_en && (wt == 3'h0) && (wv[7:6] == 2'h0);
  assign wr_phys0 = msg_wr_en && !msg_wr_data[4] && (wd == 8'h00);
  assign clr_idle = (ldt_clr_en == '0) && (mbox_clr_en == '0);

  chk_fixed_both: assert property (
    wr_fixed_vec00 && msg_wr_data[4] && (wd[1:0] == 2'h3) && (ldt_clr_en == '0)
    |=> link_irq[0][$past(wv[5:0])] && link_irq[1][$past(wv[5:0])])
    else $error("fixed message missed a selected CPU");

  chk_arb_lowest: assert property (
    msg_wr_en && (wt == 3'h1) && msg_wr_data[4] && (wd[1:0] == 2'h3)
    |=> last_tgt == 2'h1)
    else $error("arbitrated message not sent to lowest CPU");

  chk_phys_dest: assert property (
    msg_wr_en && (wt == 3'h0) && !msg_wr_data[4] && (wd == 8'h01)
    |=> last_tgt == 2'h2)
    else $error("physical destination decoded wrongly");

  chk_nv_vector: assert property (
    msg_wr_en && (wt >= 3'h2) && (wt <= 3'h6)
    |=> last_vec == 8'($past(wt) + 8'h30))
    else $error("non-vectored type gave wrong vector");

  chk_vec_field: assert property (
    msg_wr_en && (wt <= 3'h1) |=> last_vec == $past(wv))
    else $error("vector not taken from bits 20:13");

  chk_mbox_set: assert property (
    msg_wr_en && (wt == 3'h0) && !msg_wr_data[4] && (wd == 8'h00)
    && (wv[7:6] == 2'h1) && !mbox_clr_en[0]
    |=> mbox[0][$past(wv[5:0])])
    else $error("mailbox bit not set");

  chk_discard: assert property (
    msg_wr_en && (wt <= 3'h1) && wv[7] && clr_idle
    |=> msg_drop && $stable(link_irq) && $stable(mbox))
    else $error("high vector message not discarded");

  chk_reserved: assert property (
    msg_wr_en && (wt == 3'h7) && clr_idle
    |=> msg_drop && (link_irq == $past(link_irq)) && $stable(mbox))
    else $error("reserved type was delivered");

  chk_clr_ones: assert property (
    ldt_clr_en[0] && !msg_wr_en
    |=> ((link_irq[0] & $past(ldt_clr_data)) == 64'h0)
    && ((link_irq[0] | $past(ldt_clr_data)) == ($past(link_irq[0]) | $past(ldt_clr_data))))
    else $error("link-interrupt clear misbehaved");

  chk_iack_route: assert property (
    iack_rd_en |=> (iack_pci_req == !$past(southbridge_on_link_cfg))
    && (iack_link_req == $past(southbridge_on_link_cfg)))
    else $error("acknowledge read routed wrongly");

  chk_link_set: assert property (
    wr_phys0 && (wt == 3'h0) && (wv[7:6] == 2'h0)
    |=> link_irq[0][$past(wv[5:0])] && (last_tgt == 2'h1))
    else $error("link-interrupt bit not set");

  chk_set_wins: assert property (
    wr_phys0 && (wt == 3'h0) && (wv[7:6] == 2'h0) && ldt_clr_en[0] && ldt_clr_data[wv[5:0]]
    |=> link_irq[0][$past(wv[5:0])])
    else $error("clear in the same cycle hid a new message");

  chk_nv_link: assert property (
    wr_phys0 && (wt >= 3'h2) && (wt <= 3'h6)
    |=> link_irq[0][$past(wt) + 6'h30] && (last_tgt == 2'h1))
    else $error("non-vectored message did not reach its fixed bit");

  chk_logical_one: assert property (
    msg_wr_en && (wt <= 3'h1) && msg_wr_data[4] && (wd[1:0] == 2'h2)
    |=> last_tgt == 2'h2)
    else $error("logical destination bit selected the wrong CPU");

  chk_phys_none: assert property (
    msg_wr_en && (wt <= 3'h1) && !msg_wr_data[4] && (wd >= 8'h02)
    |=> msg_drop && (last_tgt == 2'h0))
    else $error("physical number beyond the CPUs was delivered");

  chk_arb_single: assert property (
    msg_wr_en && (wt == 3'h1)
    |=> $onehot0(last_tgt))
    else $error("arbitrated message reached more than one CPU");

  chk_high_ignored: assert property (
    wr_phys0 && (wt == 3'h0) && (wv == 8'h03) && (msg_wr_data[63:21] != '0)
    |=> link_irq[0][3] && (last_vec == 8'h03) && (last_tgt == 2'h1))
    else $error("bits above the vector changed the decode");

  chk_mbox_only: assert property (
    wr_phys0 && (wt == 3'h0) && (wv[7:6] == 2'h1) && clr_idle
    |=> $stable(link_irq) && !msg_drop)
    else $error("mailbox message touched the link-interrupt register");

  chk_rsvd_tgt: assert property (
    msg_wr_en && (wt == 3'h7)
    |=> last_tgt == 2'h0)
    else $error("reserved type reported a target");

  chk_fixed_phys1: assert property (
    msg_wr_en && (wt == 3'h0) && !msg_wr_data[4] && (wd == 8'h01) && (wv[7:6] == 2'h0) && clr_idle
    |=> link_irq[1][$past(wv[5:0])] && $stable(link_irq[0]))
    else $error("fixed message went to the wrong CPU");

  chk_done_pulse: assert property (
    msg_done == $past(msg_wr_en))
    else $error("message done pulse out of step with the write");

  chk_drop_done: assert property (
    msg_drop |-> msg_done)
    else $error("drop reported without a message");

  chk_level_copy: assert property (
    msg_wr_en |=> last_level == $past(msg_wr_data[3]))
    else $error("trigger mode not reported");

  chk_iack_quiet: assert property (
    !iack_rd_en |=> !iack_link_req && !iack_pci_req)
    else $error("acknowledge request without a read");

  chk_mbox_clr: assert property (
    mbox_clr_en[1] && !msg_wr_en
    |=> (mbox[1] & $past(mbox_clr_data)) == 64'h0)
    else $error("mailbox clear left bits set");

  chk_pend_flag: assert property (
    link_irq_pend[0] == (link_irq[0] != 64'h0))
    else $error("pending flag disagrees with the register");

  cov_fixed: cover property (wr_fixed_vec00 ##1 msg_done);
  cov_arb: cover property (msg_wr_en && (wt == 3'h1) ##1 !msg_drop);
  cov_drop: cover property (msg_wr_en ##1 msg_drop);
  cov_iack_pci: cover property (iack_pci_req);
  cov_mbox: cover property (msg_wr_en ##1 $rose(mbox_pend[0]));
endmodule : hid_msg_decoder

/* design/hid_pkg.sv */
package hid_pkg;
  localparam int          REG_W        = 64;
  localparam int          TYPE_LSB     = 0;
  localparam int          TYPE_W       = 3;
  localparam int          TRIG_BIT     = 3;
  localparam int          DMODE_BIT    = 4;
  localparam int          DEST_LSB     = 5;
  localparam int          DEST_W       = 8;
  localparam int          VEC_LSB      = 13;
  localparam int          VEC_W        = 8;
  localparam int          IDX_W        = 6;
  localparam logic [7:0]  NV_VEC_BASE  = 8'h32;
  localparam logic [1:0]  DELIV_LINK   = 2'h0;
  localparam logic [1:0]  DELIV_MBOX   = 2'h1;
  localparam logic [63:0] LINK_IRQ_RST = 64'h0;
  localparam logic [63:0] MBOX_RST     = 64'h0;
  localparam logic [7:0]  VEC_RST      = 8'h00;

  typedef enum logic [2:0] {
    HID_MT_FIXED = 3'b000,
    HID_MT_ARB   = 3'b001,
    HID_MT_SMI   = 3'b010,
    HID_MT_NMI   = 3'b011,
    HID_MT_INIT  = 3'b100,
    HID_MT_START = 3'b101,
    HID_MT_EXTI  = 3'b110,
    HID_MT_RSVD  = 3'b111
  } hid_msg_type_t;
endpackage : hid_pkg

/* test/hid_host_bridge.sv */
`timescale 1ns/1ps
module hid_host_bridge (
  // clock
  input  wire logic        clk,
  // message register write
  output logic             msg_wr_en,
  output logic      [63:0] msg_wr_data
);
  logic eoi_due;
  initial begin
    msg_wr_en   = 1'b0;
    msg_wr_data = 64'h0;
    eoi_due     = 1'b0;
  end
  // writes go out one per edge in call order; never reads the end-of-interrupt space
  task automatic send(input logic [63:0] d);
    logic [2:0] ty;
    ty = d[2:0];
    // a level source stays silent until its end-of-interrupt write
    while (d[3] && eoi_due) @(posedge clk);
    if (d[3] && !(ty >= 3'h2 && ty <= 3'h6)) eoi_due = 1'b1;
    @(posedge clk);
    msg_wr_en   <= 1'b1;
    // non-vectored kinds are always sent as edge triggered
    msg_wr_data <= (ty >= 3'h2 && ty <= 3'h6) ? (d & ~64'h8) : d;
  endtask : send
  // released data shows the inverse, so a stale value cannot pass by accident
  task automatic idle();
    @(posedge clk);
    msg_wr_en   <= 1'b0;
    msg_wr_data <= ~msg_wr_data;
  endtask : idle
  // software's end-of-interrupt write releases the level source
  task automatic eoi();
    eoi_due = 1'b0;
  endtask : eoi
endmodule : hid_host_bridge

/* test/test_hid_msg_decoder.sv */
`timescale 1ns/1ps
module test_hid_msg_decoder;
  typedef struct packed {
    logic [63:0] m;
    logic [1:0]  t;
    logic [1:0]  k;
    logic [5:0]  i;
  } hid_row_t;
  logic             clk, arst_n, msg_wr_en, iack_rd_en, cfg;
  logic      [63:0] msg_wr_data, ldt_clr_data, mbox_clr_data, e;
  logic      [1:0]  ldt_clr_en, mbox_clr_en, last_tgt, link_irq_pend, mbox_pend;
  logic [1:0][63:0] link_irq, mbox;
  logic      [7:0]  last_vec, ev;
  logic             last_level, msg_done, msg_drop, iack_link_req, iack_pci_req;
  int               fails, checks;
  hid_row_t         rows [15];
  hid_host_bridge i_hid_host_bridge (.clk(clk), .msg_wr_en(msg_wr_en), .msg_wr_data(msg_wr_data));
  hid_msg_decoder #(.NUM_CPU(2)) i_hid_msg_decoder (
    .clk(clk), .arst_n(arst_n), .msg_wr_en(msg_wr_en), .msg_wr_data(msg_wr_data),
    .ldt_clr_en(ldt_clr_en), .ldt_clr_data(ldt_clr_data), .mbox_clr_en(mbox_clr_en),
    .mbox_clr_data(mbox_clr_data), .iack_rd_en(iack_rd_en), .southbridge_on_link_cfg(cfg),
    .link_irq(link_irq), .mbox(mbox), .link_irq_pend(link_irq_pend), .mbox_pend(mbox_pend),
    .last_vec(last_vec), .last_tgt(last_tgt), .last_level(last_level), .msg_done(msg_done),
    .msg_drop(msg_drop), .iack_link_req(iack_link_req), .iack_pci_req(iack_pci_req));
  function automatic logic [63:0] mk(logic [2:0] ty, logic tr, logic dm, logic [7:0] de, logic [7:0] ve);
    return {43'h0, ve, de, dm, tr, ty};
  endfunction : mk
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic clr(input logic [1:0] en, input logic [63:0] ld, input logic [63:0] mb);
    @(posedge clk);
    ldt_clr_en    <= en;
    mbox_clr_en   <= en;
    ldt_clr_data  <= ld;
    mbox_clr_data <= mb;
    @(posedge clk);
    ldt_clr_en    <= 2'h0;
    mbox_clr_en   <= 2'h0;
  endtask : clr
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    arst_n = 1'b0; iack_rd_en = 1'b0; cfg = 1'b0; fails = 0; checks = 0;
    ldt_clr_en = 2'h0; mbox_clr_en = 2'h0; ldt_clr_data = 64'h0; mbox_clr_data = 64'h0;
    rows[0] = '{mk(3'h0, 1'b0, 1'b1, 8'h03, 8'h05), 2'h3, 2'h0, 6'h05};
    rows[1] = '{mk(3'h1, 1'b0, 1'b1, 8'h03, 8'h07), 2'h1, 2'h0, 6'h07};
    rows[2] = '{mk(3'h1, 1'b0, 1'b1, 8'h02, 8'h01), 2'h2, 2'h0, 6'h01};
    rows[3] = '{mk(3'h0, 1'b1, 1'b0, 8'h01, 8'h41), 2'h2, 2'h1, 6'h01};
    rows[4] = '{mk(3'h0, 1'b0, 1'b0, 8'h02, 8'h05), 2'h0, 2'h2, 6'h00};
    rows[5] = '{mk(3'h0, 1'b0, 1'b0, 8'h00, 8'h80), 2'h0, 2'h2, 6'h00};
    rows[6] = '{mk(3'h0, 1'b0, 1'b0, 8'h00, 8'hC0), 2'h0, 2'h2, 6'h00};
    rows[7] = '{mk(3'h7, 1'b0, 1'b0, 8'h00, 8'h05), 2'h0, 2'h2, 6'h00};
    rows[8] = '{mk(3'h0, 1'b0, 1'b0, 8'h00, 8'h03) | 64'hFFFF_FFFF_FFE0_0000, 2'h1, 2'h0, 6'h03};
    for (int n = 2; n <= 6; n++) rows[7+n] = '{mk(n[2:0], 1'b0, 1'b0, 8'h00, 8'h00), 2'h1, 2'h0, 6'h30 + n[5:0]};
    rows[14] = '{mk(3'h0, 1'b0, 1'b0, 8'h01, 8'h09), 2'h2, 2'h0, 6'h09};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("link_irq0", link_irq[0], 64'h0);
    chk("link_irq1", link_irq[1], 64'h0);
    chk("mbox0", mbox[0], 64'h0);
    chk("mbox1", mbox[1], 64'h0);
    chk("msg_done", msg_done, 1'b0);
    // each row goes in as a plain register write, the same path a cpu test write takes
    foreach (rows[r]) begin
      clr(2'h3, '1, '1);
      i_hid_host_bridge.send(rows[r].m);
      i_hid_host_bridge.idle();
      #1;
      e  = 64'h1 << rows[r].i;
      ev = (rows[r].m[2:0] >= 3'h2 && rows[r].m[2:0] <= 3'h6) ? 8'h30 + rows[r].m[2:0] : rows[r].m[20:13];
      chk("link_irq0", link_irq[0], (rows[r].k == 2'h0 && rows[r].t[0]) ? e : 64'h0);
      chk("link_irq1", link_irq[1], (rows[r].k == 2'h0 && rows[r].t[1]) ? e : 64'h0);
      chk("mbox0", mbox[0], (rows[r].k == 2'h1 && rows[r].t[0]) ? e : 64'h0);
      chk("mbox1", mbox[1], (rows[r].k == 2'h1 && rows[r].t[1]) ? e : 64'h0);
      chk("msg_drop", msg_drop, rows[r].k == 2'h2);
      chk("msg_done", msg_done, 1'b1);
      chk("last_level", last_level, rows[r].m[3]);
      if (rows[r].k != 2'h2) chk("last_tgt", last_tgt, rows[r].t);
      if (rows[r].m[2:0] != 3'h7) chk("last_vec", last_vec, ev);
      if (rows[r].m[3]) i_hid_host_bridge.eoi();
    end
    // back to back, with a clear landing on the second message's edge
    clr(2'h3, '1, '1);
    i_hid_host_bridge.send(mk(3'h0, 1'b0, 1'b0, 8'h00, 8'h02));
    i_hid_host_bridge.send(mk(3'h0, 1'b0, 1'b0, 8'h00, 8'h04));
    ldt_clr_en   <= 2'h1;
    ldt_clr_data <= 64'h14;
    i_hid_host_bridge.idle();
    ldt_clr_en   <= 2'h0;
    #1;
    chk("link_irq0", link_irq[0], 64'h10);
    i_hid_host_bridge.send(mk(3'h0, 1'b0, 1'b0, 8'h00, 8'h45));
    i_hid_host_bridge.idle();
    clr(2'h1, 64'h0, 64'h20);
    #1;
    chk("link_irq0", link_irq[0], 64'h10);
    chk("mbox0", mbox[0], 64'h0);
    chk("pend", {link_irq_pend, mbox_pend}, 4'h4);
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      cfg        <= c[0];
      iack_rd_en <= 1'b1;
      @(posedge clk);
      iack_rd_en <= 1'b0;
      #1;
      chk("iack_pci_req", iack_pci_req, c == 0);
      chk("iack_link_req", iack_link_req, c == 1);
    end
    // reset in mid-run clears the registers at once
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    chk("link_irq0", link_irq[0], 64'h0);
    chk("link_irq1", link_irq[1], 64'h0);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("last_vec", last_vec, 8'h00);
    chk("last_tgt", last_tgt, 2'h0);
    chk("msg_done", msg_done, 1'b0);
    @(posedge clk);
    conclude();
  end
endmodule : test_hid_msg_decoder
